//--- memory_port_decode_and_input_mux_tb.sv
// self-checking bench for page decode, port decode, input mux and wait logic
`timescale 1ns/1ps
`default_nettype none
module memory_port_decode_and_input_mux_tb;
  logic core_clk;
  logic rst_n;
  logic [15:0] cpuAddr;
  mpdec_pkg::mpdec_status_t status;
  logic syncStrobe, dataInStrobe, writeStrobe_n, intAckJumper, addrDisable_n;
  logic selA, selB, rom0N, rom1N, ramN, dispN, weN, memSel, intSel, ready, startupN, addrEn;
  logic [4:0] row, col;
  logic [7:0] inS, outS;
  logic [37:0] seen, w;
  logic [37:0] notes[$];
  int nFail = 0;
  int cmpCount = 0;
  int cnt = 0;
  logic dinPrev = 1'b0;
  int i;

  mpdec_cpu_model cpu (.core_clk(core_clk), .cpuAddr(cpuAddr), .status(status), .syncStrobe(syncStrobe),
    .dataInStrobe(dataInStrobe), .writeStrobe_n(writeStrobe_n), .intAckJumper(intAckJumper),
    .addrDisable_n(addrDisable_n));
  mpdec_decode DUT (.core_clk(core_clk), .rst_n(rst_n), .cpuAddr(cpuAddr), .status(status),
    .syncStrobe(syncStrobe), .dataInStrobe(dataInStrobe), .writeStrobe_n(writeStrobe_n),
    .intAckJumper(intAckJumper), .addrDisable_n(addrDisable_n), .input_select_a(selA),
    .input_select_b(selB), .romPage0Sel_n(rom0N), .romPage1Sel_n(rom1N), .ramPageSel_n(ramN),
    .display_page_sel_n(dispN), .ramWriteEn_n(weN), .ramRow(row), .ramCol(col), .memSel(memSel),
    .inPortStrobe_n(inS), .outPortStrobe_n(outS), .intSel(intSel), .ready(ready),
    .startup_n(startupN), .addrDriveEn(addrEn));

  assign seen = {selA, selB, dispN, ramN, rom1N, rom0N, weN, row, col, memSel, inS, outS, intSel, ready,
    startupN, addrEn};

  // 8 ns clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // s = {memRead, memWrite, inStat, outStat, intAck}; start-up state used before this cycle's strobe counts
  function automatic logic [37:0] expectOut(logic [15:0] a, logic [4:0] s, logic [4:0] c);
    logic [3:0] pg;
    logic [7:0] ip, op;
    logic ia, ms, isel, ov, su;
    su = (cnt == 4);
    ia = c[1] & s[0];
    pg = 4'hF;
    ip = 8'hFF;
    op = 8'hFF;
    if (!s[2] && !s[1] && !ia) begin
      if (!su && a[15:10] == 6'h00) pg[0] = 1'b0;
      else if (su && a[15:12] == 4'hC) pg[a[11:10]] = 1'b0;
    end
    if (a[15:11] == 5'h1F && !ia) begin
      if (c[3] && s[2]) ip[a[10:8]] = 1'b0;
      if (s[1] && !c[2]) op[a[10:8]] = 1'b0;
    end
    ms = ~&pg;
    isel = ~&ip[3:0];
    ov = ms & pg[3];
    if (c[3] && !dinPrev && cnt < 4) cnt++;
    dinPrev = c[3];
    return {!(!ip[4] | isel | ov), !(!ip[5] | isel | ov), pg, !(!pg[2] & s[3]), a[4:0], a[9:5], ms, ip, op,
      isel, !(c[4] & (ms | s[2] | s[1])), cnt == 4, c[0]};
  endfunction : expectOut

  // one bus cycle; its outcome is noted for the watcher
  task automatic go(input logic [15:0] a, input logic [4:0] s, input logic [4:0] c);
    cpu.issue(a, s, c);
    notes.push_back(expectOut(a, s, c));
  endtask : go

  task automatic check(input logic [37:0] got, input logic [37:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finishTest();
    if (nFail == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finishTest

  // outputs land one edge after the inputs, so the oldest note matches once a newer one exists
  always @(negedge core_clk) begin
    if (notes.size() > 1) begin
      w = notes.pop_front();
      check(38'(seen[37:31]), 38'(w[37:31]));
      check(38'(seen[30:3]), 38'(w[30:3]));
      check(38'(seen[2:0]), 38'(w[2:0]));
    end
  end

  // a hang counts as a failure
  initial begin
    #200000;
    nFail++;
    finishTest();
  end

  initial begin
    rst_n = 1'b0;
    void'($urandom(72));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    // start-up: page zero answers, c-range dark; fourth strobe kept off any page
    for (i = 0; i < 3; i++) begin
      go(16'h0100, 5'h10, 5'h1D);
      go(16'hC000, 5'h10, 5'h05);
    end
    go(16'hFF00, 5'h00, 5'h0D);
    go(16'h0100, 5'h10, 5'h15);
    go(16'hC000, 5'h10, 5'h15);
    // every input and output port, with sync so ready drops
    for (i = 0; i < 8; i++) begin
      go({5'h1F, i[2:0], 8'h5A}, 5'h04, 5'h1D);
      go({5'h1F, i[2:0], 8'hA5}, 5'h02, 5'h11);
    end
    // refusals: outside port space, missing strobes, jumpered acknowledge, pages under I/O status; bare acknowledge decodes
    go(16'hF700, 5'h04, 5'h0D);
    go(16'hFC00, 5'h04, 5'h05);
    go(16'hFD00, 5'h02, 5'h05);
    go(16'hFC00, 5'h05, 5'h0F);
    go(16'hFC00, 5'h05, 5'h0D);
    go(16'hC400, 5'h11, 5'h07);
    go(16'hC800, 5'h14, 5'h15);
    go(16'hCC00, 5'h02, 5'h14);
    // all four pages read then written, random row and column
    for (i = 0; i < 8; i++) go({4'hC, i[1:0], 10'($urandom)}, i[2] ? 5'h08 : 5'h10, 5'h15);
    // random traffic biased to the decoded ranges
    repeat (80) go({($urandom % 2) ? 4'hC : 4'hF, 12'($urandom)}, 5'($urandom), 5'($urandom));
    go(16'h0000, 5'h00, 5'h05);
    go(16'h0000, 5'h00, 5'h05);
    @(posedge core_clk);
    @(posedge core_clk);
    finishTest();
  end
endmodule : memory_port_decode_and_input_mux_tb
`default_nettype wire

//--- mpdec_cpu_model.sv
// processor-side model: address, status and strobes, one bus cycle per clock
`timescale 1ns/1ps
`default_nettype none
module mpdec_cpu_model (
  input wire logic core_clk,
  output logic [15:0] cpuAddr,
  output var mpdec_pkg::mpdec_status_t status,
  output logic syncStrobe,
  output logic dataInStrobe,
  output logic writeStrobe_n,
  output logic intAckJumper,
  output logic addrDisable_n
);
  // idle bus at time zero; address drivers left enabled
  initial begin
    cpuAddr = 16'h0000;
    status = '0;
    {syncStrobe, dataInStrobe, writeStrobe_n, intAckJumper} = 4'h2;
    addrDisable_n = 1'b1;
  end

  // ctl = {sync, data-in, write_n, jumper, addr-disable_n}; sync comes from ctl, so some cycles start without it
  // addr-disable goes low only when a scenario hands the bus away
  task automatic issue(input logic [15:0] a, input logic [4:0] s, input logic [4:0] ctl);
    @(posedge core_clk);
    cpuAddr <= a;
    status <= mpdec_pkg::mpdec_status_t'(s);
    {syncStrobe, dataInStrobe, writeStrobe_n, intAckJumper, addrDisable_n} <= ctl;
  endtask : issue
endmodule : mpdec_cpu_model
`default_nettype wire

//--- mpdec_decode.sv
// page decode, port decode, input mux select and wait-state logic
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mpdec_map.svh"
module mpdec_decode (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] cpuAddr,
  input wire mpdec_pkg::mpdec_status_t status,
  input wire logic syncStrobe,
  input wire logic dataInStrobe,
  input wire logic writeStrobe_n,
  input wire logic intAckJumper,
  input wire logic addrDisable_n,
  output logic input_select_a,
  output logic input_select_b,
  output logic romPage0Sel_n,
  output logic romPage1Sel_n,
  output logic ramPageSel_n,
  output logic display_page_sel_n,
  output logic ramWriteEn_n,
  output logic [4:0] ramRow,
  output logic [4:0] ramCol,
  output logic memSel,
  output logic [7:0] inPortStrobe_n,
  output logic [7:0] outPortStrobe_n,
  output logic intSel,
  output logic ready,
  output logic startup_n,
  output logic addrDriveEn
);
  logic [2:0] strobeCount;
  logic prevDataIn;
  logic waitPending;
  logic startupActive;
  logic intAckBlock;
  logic pageHit;
  logic [1:0] pageIdx;
  logic [3:0] next_page_n;
  logic next_memSel;
  logic portHit;
  logic inDecode;
  logic outDecode;
  logic [7:0] next_in_n;
  logic [7:0] next_out_n;
  logic next_intSel;
  logic next_a;
  logic next_b;
  logic ioCycle;

  assign startupActive = (strobeCount < `MPDEC_STARTUP_STROBES);
  assign intAckBlock = intAckJumper && status.intAck; // [RULE20]

  // page decode; start-up remaps page zero onto the first ROM page
  always_comb begin
    pageHit = 1'b0;
    pageIdx = cpuAddr[11:10];
    if (startupActive) begin
      pageHit = (cpuAddr[15:10] == 6'h00); // [RULE12]
      pageIdx = `MPDEC_PG_C0;
    end else begin
      pageHit = (cpuAddr[15:12] == `MPDEC_PAGE_HI); // [RULE10]
    end
    if (status.inStat || status.outStat || intAckBlock) begin
      pageHit = 1'b0; // [RULE13] [RULE20]
    end
    next_page_n = 4'hF;
    if (pageHit) begin
      next_page_n[pageIdx] = 1'b0;
    end
    next_memSel = ~&next_page_n; // [RULE11]
  end

  // port decode; no I/O happens during start-up so no remap is needed
  always_comb begin
    portHit = ({cpuAddr[15:12], cpuAddr[11]} == `MPDEC_PORT_HI) && !intAckBlock; // [RULE16] [RULE20]
    inDecode = portHit && dataInStrobe && status.inStat; // [RULE18]
    outDecode = portHit && status.outStat && !writeStrobe_n; // [RULE18]
    next_in_n = 8'hFF;
    next_out_n = 8'hFF;
    if (inDecode) begin
      next_in_n[cpuAddr[10:8]] = 1'b0; // [RULE17]
    end
    if (outDecode) begin
      next_out_n[cpuAddr[10:8]] = 1'b0; // [RULE17]
    end
    next_intSel = inDecode && !cpuAddr[10]; // [RULE19]
  end

  // mux select: display page wins over memory select
  always_comb begin
    next_a = 1'b1; // [RULE23]
    next_b = 1'b1;
    if (!next_page_n[`MPDEC_PG_CC]) begin
      next_a = 1'b1; // [RULE6]
      next_b = 1'b1;
    end else if (next_memSel || next_intSel) begin
      next_a = 1'b0; // [RULE5] [RULE4]
      next_b = 1'b0;
    end else if (!next_in_n[`MPDEC_PORT_KBD]) begin
      next_a = 1'b0; // [RULE2]
    end else if (!next_in_n[`MPDEC_PORT_PAR]) begin
      next_b = 1'b0; // [RULE3]
    end
  end

  assign ioCycle = next_memSel || status.inStat || status.outStat;

  // registered decode outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_select_a <= 1'b1;
      input_select_b <= 1'b1;
      {display_page_sel_n, ramPageSel_n, romPage1Sel_n, romPage0Sel_n} <= 4'hF;
      memSel <= 1'b0;
      inPortStrobe_n <= 8'hFF;
      outPortStrobe_n <= 8'hFF;
      intSel <= 1'b0;
    end else begin
      input_select_a <= next_a; // [RULE1]
      input_select_b <= next_b; // [RULE1]
      {display_page_sel_n, ramPageSel_n, romPage1Sel_n, romPage0Sel_n} <= next_page_n; // [RULE9] [RULE11]
      memSel <= next_memSel;
      inPortStrobe_n <= next_in_n;
      outPortStrobe_n <= next_out_n;
      intSel <= next_intSel;
    end
  end

  // ram array addressing; write enable only follows memory-write on the RAM page
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramWriteEn_n <= 1'b1;
      ramRow <= 5'h00;
      ramCol <= 5'h00;
    end else begin
      ramRow <= cpuAddr[4:0]; // [RULE7]
      ramCol <= cpuAddr[9:5]; // [RULE7]
      ramWriteEn_n <= !(status.memWrite && !next_page_n[`MPDEC_PG_C8]); // [RULE8]
    end
  end

  // one wait state: forced at sync of a memory or I/O cycle, released at the next clock edge after sync
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitPending <= 1'b0;
      ready <= 1'b1;
    end else begin
      waitPending <= syncStrobe; // [RULE15]
      ready <= !(syncStrobe && ioCycle); // [RULE14] [RULE15]
    end
  end

  // start-up counter: counts data-in rising edges, saturates at four
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobeCount <= 3'h0;
      prevDataIn <= 1'b0;
      startup_n <= 1'b0;
    end else begin
      prevDataIn <= dataInStrobe;
      if (dataInStrobe && !prevDataIn && startupActive) begin
        strobeCount <= strobeCount + 3'h1; // [RULE22]
      end
      startup_n <= !(startupActive && !(dataInStrobe && !prevDataIn && strobeCount == 3'h3)); // [RULE22]
    end
  end

  // address drivers follow the bus disable line
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrDriveEn <= 1'b1;
    end else begin
      addrDriveEn <= addrDisable_n; // [RULE21]
    end
  end

  property p_kbd_sel;
    @(posedge core_clk) disable iff (!rst_n)
      !inPortStrobe_n[`MPDEC_PORT_KBD] |-> !input_select_a && input_select_b;
  endproperty
  a_kbd_sel: assert property (p_kbd_sel) else $error("keyboard read wrong select"); // [RULE2]

  property p_par_sel;
    @(posedge core_clk) disable iff (!rst_n)
      !inPortStrobe_n[`MPDEC_PORT_PAR] |-> input_select_a && !input_select_b;
  endproperty
  a_par_sel: assert property (p_par_sel) else $error("parallel read wrong select"); // [RULE3]

  property p_int_sel;
    @(posedge core_clk) disable iff (!rst_n)
      intSel |-> !input_select_a && !input_select_b && (inPortStrobe_n[3:0] != 4'hF);
  endproperty
  a_int_sel: assert property (p_int_sel) else $error("internal port select wrong"); // [RULE4]

  property p_disp_sel;
    @(posedge core_clk) disable iff (!rst_n)
      !display_page_sel_n |-> input_select_a && input_select_b && memSel;
  endproperty
  a_disp_sel: assert property (p_disp_sel) else $error("display page select wrong"); // [RULE6]

  property p_mem_sel;
    @(posedge core_clk) disable iff (!rst_n)
      (memSel && display_page_sel_n) |-> !input_select_a && !input_select_b;
  endproperty
  a_mem_sel: assert property (p_mem_sel) else $error("memory select wrong"); // [RULE5]

  property p_io_no_page;
    @(posedge core_clk) disable iff (!rst_n)
      (status.inStat || status.outStat) |=> !memSel;
  endproperty
  a_io_no_page: assert property (p_io_no_page) else $error("page decoded during io"); // [RULE13]

  sequence s_sync_io;
    syncStrobe && (status.inStat || status.outStat);
  endsequence
  property p_wait;
    @(posedge core_clk) disable iff (!rst_n)
      s_sync_io |=> !ready ##1 (ready || $past(syncStrobe));
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle"); // [RULE14]

  property p_port_range;
    @(posedge core_clk) disable iff (!rst_n)
      (inPortStrobe_n != 8'hFF) |-> $past(cpuAddr[15:11]) == 5'h1F;
  endproperty
  a_port_range: assert property (p_port_range) else $error("port strobe out of range"); // [RULE16]

  property p_startup;
    @(posedge core_clk) disable iff (!rst_n)
      (strobeCount < 3'h3) |=> !startup_n;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up ended early"); // [RULE22]

  property p_idle;
    @(posedge core_clk) disable iff (!rst_n)
      (!memSel && !intSel && inPortStrobe_n == 8'hFF) |-> input_select_a && input_select_b;
  endproperty
  a_idle: assert property (p_idle) else $error("idle select not bidir"); // [RULE23]

  // wait flop mirrors the sync of the previous cycle; ready may only drop behind it
  property p_wait_release;
    @(posedge core_clk) disable iff (!rst_n)
      !ready |-> waitPending;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("ready low without sync"); // [RULE15]

  sequence s_sync_mem;
    syncStrobe && next_memSel;
  endsequence
  property p_mem_wait;
    @(posedge core_clk) disable iff (!rst_n)
      s_sync_mem |=> !ready;
  endproperty
  a_mem_wait: assert property (p_mem_wait) else $error("memory cycle without wait"); // [RULE14]

  property p_no_wait_idle;
    @(posedge core_clk) disable iff (!rst_n)
      !syncStrobe |=> ready;
  endproperty
  a_no_wait_idle: assert property (p_no_wait_idle) else $error("wait held past sync"); // [RULE15]

  property p_ram_addr;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (ramRow == $past(cpuAddr[4:0])) && (ramCol == $past(cpuAddr[9:5]));
  endproperty
  a_ram_addr: assert property (p_ram_addr) else $error("ram row or column wrong"); // [RULE7]

  property p_ram_write_page;
    @(posedge core_clk) disable iff (!rst_n)
      !ramWriteEn_n |-> !ramPageSel_n;
  endproperty
  a_ram_write_page: assert property (p_ram_write_page) else $error("ram write off its page"); // [RULE8]

  property p_ram_write_src;
    @(posedge core_clk) disable iff (!rst_n)
      !ramWriteEn_n |-> $past(status.memWrite);
  endproperty
  a_ram_write_src: assert property (p_ram_write_src) else $error("ram write without memory write"); // [RULE8]

  // at most one page enable at a time
  property p_page_onehot;
    @(posedge core_clk) disable iff (!rst_n)
      $onehot0(~{display_page_sel_n, ramPageSel_n, romPage1Sel_n, romPage0Sel_n});
  endproperty
  a_page_onehot: assert property (p_page_onehot) else $error("two pages enabled"); // [RULE10]

  property p_mem_sel_or;
    @(posedge core_clk) disable iff (!rst_n)
      memSel == !(&{display_page_sel_n, ramPageSel_n, romPage1Sel_n, romPage0Sel_n});
  endproperty
  a_mem_sel_or: assert property (p_mem_sel_or) else $error("memory select not page or"); // [RULE11]

  property p_page_range;
    @(posedge core_clk) disable iff (!rst_n)
      (!romPage1Sel_n || !ramPageSel_n || !display_page_sel_n) |-> $past(cpuAddr[15:12]) == 4'hC;
  endproperty
  a_page_range: assert property (p_page_range) else $error("page outside c range"); // [RULE10]

  property p_startup_map;
    @(posedge core_clk) disable iff (!rst_n)
      (!startup_n && !romPage0Sel_n) |-> $past(cpuAddr[15:10]) == 6'h00;
  endproperty
  a_startup_map: assert property (p_startup_map) else $error("start-up rom not at page zero"); // [RULE12]

  property p_startup_dark;
    @(posedge core_clk) disable iff (!rst_n)
      !startup_n |-> display_page_sel_n && ramPageSel_n && romPage1Sel_n;
  endproperty
  a_startup_dark: assert property (p_startup_dark) else $error("c page decoded in start-up"); // [RULE12]

  property p_in_port;
    @(posedge core_clk) disable iff (!rst_n)
      (inPortStrobe_n != 8'hFF) |-> $past(status.inStat) && $past(dataInStrobe);
  endproperty
  a_in_port: assert property (p_in_port) else $error("input strobe without qualifiers"); // [RULE18]

  property p_out_port;
    @(posedge core_clk) disable iff (!rst_n)
      (outPortStrobe_n != 8'hFF) |-> $past(status.outStat) && !$past(writeStrobe_n);
  endproperty
  a_out_port: assert property (p_out_port) else $error("output strobe without qualifiers"); // [RULE18]

  property p_port_index;
    @(posedge core_clk) disable iff (!rst_n)
      (inPortStrobe_n != 8'hFF) |-> inPortStrobe_n == ~(8'h01 << $past(cpuAddr[10:8]));
  endproperty
  a_port_index: assert property (p_port_index) else $error("input strobe index wrong"); // [RULE17]

  property p_port_onehot;
    @(posedge core_clk) disable iff (!rst_n)
      $onehot0(~inPortStrobe_n) && $onehot0(~outPortStrobe_n);
  endproperty
  a_port_onehot: assert property (p_port_onehot) else $error("two port strobes at once"); // [RULE17]

  // jumpered acknowledge must keep every decoder dark
  property p_intack_block;
    @(posedge core_clk) disable iff (!rst_n)
      (intAckJumper && status.intAck) |=> !memSel && (inPortStrobe_n == 8'hFF) && (outPortStrobe_n == 8'hFF);
  endproperty
  a_intack_block: assert property (p_intack_block) else $error("decode during acknowledge"); // [RULE20]

  property p_int_sel_ports;
    @(posedge core_clk) disable iff (!rst_n)
      intSel == (inPortStrobe_n[3:0] != 4'hF);
  endproperty
  a_int_sel_ports: assert property (p_int_sel_ports) else $error("internal select not low ports"); // [RULE19]

  property p_addr_drive;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> addrDriveEn == $past(addrDisable_n);
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address drive wrong"); // [RULE21]

  sequence s_fourth_strobe;
    dataInStrobe && !prevDataIn && (strobeCount == 3'h3);
  endsequence
  property p_startup_end;
    @(posedge core_clk) disable iff (!rst_n)
      s_fourth_strobe |=> startup_n && (strobeCount == 3'h4);
  endproperty
  a_startup_end: assert property (p_startup_end) else $error("start-up not ended at fourth"); // [RULE22]

  property p_startup_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (strobeCount == 3'h4) |=> startup_n && (strobeCount == 3'h4);
  endproperty
  a_startup_hold: assert property (p_startup_hold) else $error("start-up came back"); // [RULE22]

  property p_mux_kbd_only;
    @(posedge core_clk) disable iff (!rst_n)
      (!input_select_a && input_select_b) |-> !inPortStrobe_n[`MPDEC_PORT_KBD];
  endproperty
  a_mux_kbd_only: assert property (p_mux_kbd_only) else $error("keyboard bus without its port"); // [RULE2]

  property p_mux_par_only;
    @(posedge core_clk) disable iff (!rst_n)
      (input_select_a && !input_select_b) |-> !inPortStrobe_n[`MPDEC_PORT_PAR];
  endproperty
  a_mux_par_only: assert property (p_mux_par_only) else $error("parallel bus without its port"); // [RULE3]
endmodule : mpdec_decode
`default_nettype wire

//--- mpdec_map.svh
// constants for the memory page, port decode and input mux block
// What this block does
// RULE1: selects both high bidir, A low keyboard, B low parallel, both low internal
// RULE2: keyboard port read drives only select A low
// RULE3: parallel port read drives only select B low
// RULE4: internal-bus input ports drive both selects low
// RULE5: any on-board memory page raises memory select, both selects low
// RULE6: display page overrides memory select, both selects stay high
// RULE7: system RAM is one 1K page, row bits 0-4, column 5-9, page 10-15
// RULE8: RAM writes when memory-write is high, reads when low
// RULE9: ROM is read-only with separate enables for pages C0 and C4
// RULE10: page decode needs address 15-12 equal 1100, bits 11-10 pick page
// RULE11: page outputs drive memory enables and common memory select
// RULE12: during start-up, C-range decode blocked and page zero maps to ROM first page
// RULE13: page decoder disabled during input or output status
// RULE14: memory, input or output cycle pulls ready low for one wait state
// RULE15: ready held low from mid-sync until first phi2 rising edge after sync
// RULE16: port decoders need address 15-12 all ones and bit 11 one
// RULE17: address bits 10-8 choose which of eight port strobes
// RULE18: input decode needs data-in and input status; output needs output status and write
// RULE19: internal select active for the four lowest input ports
// RULE20: with jumper fitted, interrupt acknowledge disables page and port decoders
// RULE21: address drivers enabled unless address-disable is low
// RULE22: start-up signal low for first four data-in strobes after power-on clear
// RULE23: nothing decoded leaves both selects high, reading the bidir bus
`ifndef MPDEC_MAP_SVH
`define MPDEC_MAP_SVH
`define MPDEC_PAGE_HI 4'hC
`define MPDEC_PORT_HI 5'h1F
`define MPDEC_PG_C0 2'h0
`define MPDEC_PG_C4 2'h1
`define MPDEC_PG_C8 2'h2
`define MPDEC_PG_CC 2'h3
`define MPDEC_PORT_KBD 3'h4
`define MPDEC_PORT_PAR 3'h5
`define MPDEC_STARTUP_STROBES 3'h4
`endif

//--- mpdec_pkg.sv
// types for the memory page, port decode and input mux block
`default_nettype none
package mpdec_pkg;
  typedef struct packed {
    logic memRead;
    logic memWrite;
    logic inStat;
    logic outStat;
    logic intAck;
  } mpdec_status_t;
  typedef enum {MPDEC_SRC_BIDIR, MPDEC_SRC_KBD, MPDEC_SRC_PAR, MPDEC_SRC_INT} mpdec_src_t;
endpackage : mpdec_pkg
`default_nettype wire
